// *** rtl/ssc_setup_cmd.sv ***
// system setup command handler: power-on flags, sleep timer, beep and sync enables
`timescale 1ns/1ns

module ssc_setup_cmd
    import ssc_pkg::*;
#(
    parameter logic [27:0] P_CYC_PER_SEC = SSC_CYC_PER_SEC
) (
    // clock, reset, enable
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // front panel activity
    input wire logic i_key_press,
    // non-volatile settings store
    input wire logic [15:0] i_nv_data,
    output logic o_nv_wr,
    output logic [15:0] o_nv_data,
    // controls to the rest of the instrument
    output logic o_sleep,
    output logic o_wave_out_en,
    output logic o_key_beep_en,
    output logic o_err_beep_en,
    output logic o_sync_out_en,
    output logic o_remote_dflt
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------

    // only the seven documented minute values are legal
    function automatic logic sleep_ok(input logic [15:0] v);
        sleep_ok = (v == 16'h0000) || (v == 16'h000A) || (v == 16'h0014) || (v == 16'h001E) ||
                   (v == 16'h0028) || (v == 16'h0032) || (v == 16'h003C);
    endfunction : sleep_ok

    // numeric arg carries 4 fraction bits; ties round away from zero
    function automatic logic rounds_nonzero(input logic [15:0] v);
        rounds_nonzero = !(($signed(v) > SSC_HALF_NEG) && ($signed(v) < SSC_HALF_POS));
    endfunction : rounds_nonzero

    function automatic logic [15:0] nv_image(input ssc_regs_t r);
        logic [15:0] img;
        img = 16'h0000;
        img[SSC_NV_FAC_BIT] = r.setup_fac;
        img[SSC_NV_OFF_BIT] = r.out_off;
        img[SSC_NV_SLEEP_LSB +: 6] = r.sleep_min;
        img[SSC_NV_KEY_BIT] = r.key_beep;
        img[SSC_NV_ERR_BIT] = r.err_beep;
        img[SSC_NV_SYNC_BIT] = r.sync_en;
        img[SSC_NV_WAVE_BIT] = r.wave_on;
        nv_image = img;
    endfunction : nv_image

    // ---------------------------------------------------------------
    // command decode
    // ---------------------------------------------------------------
    ssc_regs_t s_q;
    ssc_regs_t s_d;
    logic bus_req;
    logic cmd_go;
    logic [3:0] cmd_op;
    logic cmd_query;
    logic cmd_num;
    logic [15:0] cmd_arg;
    logic [7:0] cmd_tok;
    logic activity;

    assign bus_req = i_wb_cyc && i_wb_stb && !s_q.ack;
    // partial-lane writes to the command word are ignored so a half word never executes
    assign cmd_go = bus_req && i_wb_we && (i_wb_adr == SSC_ADR_CMD) && (i_wb_sel == 4'hF) &&
                    (s_q.st == SSC_RUN);
    assign cmd_op = i_wb_dat[SSC_CMD_OP_LSB +: 4];
    assign cmd_query = i_wb_dat[SSC_CMD_QUERY_BIT];
    assign cmd_num = i_wb_dat[SSC_CMD_NUM_BIT];
    assign cmd_arg = i_wb_dat[SSC_CMD_ARG_LSB +: 16];
    assign cmd_tok = cmd_arg[7:0];
    assign activity = i_key_press || cmd_go;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic flag_set;
        logic flag_ok;
        flag_set = 1'b0;
        flag_ok = 1'b1;
        s_d = s_q;
        s_d.remote_dflt = 1'b0;
        s_d.nv_wr = 1'b0;
        // on/off style argument shared by beep, sync and wave commands
        if (cmd_num) begin
            flag_set = rounds_nonzero(cmd_arg);
        end else if (cmd_tok == SSC_TOK_ON) begin
            flag_set = 1'b1;
        end else if (cmd_tok != SSC_TOK_OFF) begin
            flag_ok = 1'b0;
        end
        // wishbone: one wait state, ack drops after one cycle
        s_d.ack = bus_req;
        if (bus_req && !i_wb_we) begin
            case (i_wb_adr)
                SSC_ADR_RESP: begin
                    s_d.rdat = {22'h000000, s_q.resp_err, s_q.resp_valid, s_q.resp_val};
                end
                SSC_ADR_STATUS: begin
                    s_d.rdat = {16'h0000, nv_image(s_q)};
                    s_d.rdat[SSC_ST_SLEEP_BIT] = s_q.asleep;
                    s_d.rdat[SSC_ST_RUN_BIT] = (s_q.st == SSC_RUN);
                end
                default: begin
                    s_d.rdat = 32'h00000000;
                end
            endcase
        end
        case (s_q.st)
            SSC_BOOT: begin
                // power-on load from the non-volatile image
                s_d.st = SSC_RUN;
                s_d.setup_fac = i_nv_data[SSC_NV_FAC_BIT];
                s_d.out_off = i_nv_data[SSC_NV_OFF_BIT];
                if (i_nv_data[SSC_NV_FAC_BIT]) begin
                    s_d.sleep_min = SSC_DEF_SLEEP;
                    s_d.key_beep = SSC_DEF_KEYB;
                    s_d.err_beep = SSC_DEF_ERRB;
                    s_d.sync_en = SSC_DEF_SYNC;
                    s_d.wave_on = 1'b0;
                    s_d.remote_dflt = 1'b1;
                end else begin
                    s_d.sleep_min = i_nv_data[SSC_NV_SLEEP_LSB +: 6];
                    // a corrupt image value falls back to the default delay
                    if (!sleep_ok({10'h000, i_nv_data[SSC_NV_SLEEP_LSB +: 6]})) begin
                        s_d.sleep_min = SSC_DEF_SLEEP;
                    end
                    s_d.key_beep = i_nv_data[SSC_NV_KEY_BIT];
                    s_d.err_beep = i_nv_data[SSC_NV_ERR_BIT];
                    s_d.sync_en = i_nv_data[SSC_NV_SYNC_BIT];
                    s_d.wave_on = i_nv_data[SSC_NV_WAVE_BIT] && !i_nv_data[SSC_NV_OFF_BIT];
                end
            end
            SSC_RUN: begin
                if (cmd_go) begin
                    s_d.resp_valid = cmd_query;
                    s_d.resp_err = 1'b0;
                    s_d.resp_val = 8'h00;
                    case (cmd_op)
                        SSC_OP_SETUP: begin
                            if (cmd_query) begin
                                s_d.resp_val = s_q.setup_fac ? SSC_TOK_FAC : SSC_TOK_LAST;
                            end else if (cmd_tok == SSC_TOK_FAC || cmd_tok == SSC_TOK_LAST) begin
                                s_d.setup_fac = (cmd_tok == SSC_TOK_FAC);
                            end else begin
                                s_d.resp_err = 1'b1;
                            end
                        end
                        SSC_OP_OUTF: begin
                            if (cmd_query) begin
                                s_d.resp_val = s_q.out_off ? SSC_TOK_OFF : SSC_TOK_LAST;
                            end else if (cmd_tok == SSC_TOK_OFF || cmd_tok == SSC_TOK_LAST) begin
                                s_d.out_off = (cmd_tok == SSC_TOK_OFF);
                            end else begin
                                s_d.resp_err = 1'b1;
                            end
                        end
                        SSC_OP_SLEEP: begin
                            if (cmd_query) begin
                                s_d.resp_val = {2'b00, s_q.sleep_min};
                            end else if (sleep_ok(cmd_arg)) begin
                                s_d.sleep_min = cmd_arg[5:0];
                            end else begin
                                s_d.resp_err = 1'b1;
                            end
                        end
                        SSC_OP_SLEEP_NOW: begin
                            // no data part and no query form
                            s_d.resp_valid = 1'b0;
                            s_d.resp_err = cmd_query;
                        end
                        SSC_OP_KEYB: begin
                            if (cmd_query) begin
                                s_d.resp_val = {7'h00, s_q.key_beep};
                            end else if (flag_ok) begin
                                s_d.key_beep = flag_set;
                            end else begin
                                s_d.resp_err = 1'b1;
                            end
                        end
                        SSC_OP_ERRB: begin
                            if (cmd_query) begin
                                s_d.resp_val = {7'h00, s_q.err_beep};
                            end else if (flag_ok) begin
                                s_d.err_beep = flag_set;
                            end else begin
                                s_d.resp_err = 1'b1;
                            end
                        end
                        SSC_OP_SYNC: begin
                            if (cmd_query) begin
                                s_d.resp_val = {7'h00, s_q.sync_en};
                            end else if (flag_ok) begin
                                s_d.sync_en = flag_set;
                            end else begin
                                s_d.resp_err = 1'b1;
                            end
                        end
                        SSC_OP_WAVE: begin
                            if (cmd_query) begin
                                s_d.resp_val = {7'h00, s_q.wave_on};
                            end else if (flag_ok) begin
                                s_d.wave_on = flag_set;
                            end else begin
                                s_d.resp_err = 1'b1;
                            end
                        end
                        default: begin
                            s_d.resp_valid = 1'b0;
                            s_d.resp_err = 1'b1;
                        end
                    endcase
                end
                // sleep timer: activity wakes and restarts, zero delay never expires
                if (activity) begin
                    s_d.cyc_cnt = 28'h0000000;
                    s_d.sec_cnt = 6'h00;
                    s_d.min_cnt = 6'h00;
                    s_d.asleep = 1'b0;
                end else if (s_q.sleep_min != 6'h00 && !s_q.asleep) begin
                    s_d.cyc_cnt = s_q.cyc_cnt + 28'h0000001;
                    if (s_q.cyc_cnt == P_CYC_PER_SEC - 28'h0000001) begin
                        s_d.cyc_cnt = 28'h0000000;
                        s_d.sec_cnt = s_q.sec_cnt + 6'h01;
                        if (s_q.sec_cnt == SSC_SEC_PER_MIN - 6'h01) begin
                            s_d.sec_cnt = 6'h00;
                            s_d.min_cnt = s_q.min_cnt + 6'h01;
                            if (s_q.min_cnt + 6'h01 >= s_q.sleep_min) begin
                                s_d.asleep = 1'b1;
                            end
                        end
                    end
                end
                // the sleep command itself counts as activity, so it must win here
                if (cmd_go && !cmd_query && cmd_op == SSC_OP_SLEEP_NOW) begin
                    s_d.asleep = 1'b1;
                end
                // keep the stored image in step with every setting change
                s_d.nv_data = nv_image(s_d);
                s_d.nv_wr = (nv_image(s_d) != nv_image(s_q));
            end
            default: begin
                s_d.st = SSC_BOOT;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_q <= '0;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign o_wb_ack = s_q.ack;
    assign o_wb_dat = s_q.rdat;
    assign o_nv_wr = s_q.nv_wr;
    assign o_nv_data = s_q.nv_data;
    assign o_sleep = s_q.asleep;
    assign o_wave_out_en = s_q.wave_on;
    assign o_key_beep_en = s_q.key_beep;
    assign o_err_beep_en = s_q.err_beep;
    assign o_sync_out_en = s_q.sync_en;
    assign o_remote_dflt = s_q.remote_dflt;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);

    logic boot_go;
    assign boot_go = i_ce && (s_q.st == SSC_BOOT);

    boot_keep_a: assert property (boot_go && !i_nv_data[SSC_NV_FAC_BIT] |=>
        o_key_beep_en == $past(i_nv_data[SSC_NV_KEY_BIT]) && o_sync_out_en == $past(i_nv_data[SSC_NV_SYNC_BIT]))
        else $error("retained setup not restored");
    boot_fac_a: assert property (boot_go && i_nv_data[SSC_NV_FAC_BIT] |=>
        o_key_beep_en == SSC_DEF_KEYB && s_q.sleep_min == SSC_DEF_SLEEP && o_remote_dflt ##1 !o_remote_dflt)
        else $error("factory setup not loaded");
    remote_dflt_a: assert property ($rose(o_remote_dflt) |-> $past(boot_go && i_nv_data[SSC_NV_FAC_BIT]))
        else $error("remote defaults pulsed without factory option");
    setup_query_a: assert property (cmd_go && i_ce && cmd_query && cmd_op == SSC_OP_SETUP |=>
        s_q.resp_valid && s_q.resp_val == (s_q.setup_fac ? SSC_TOK_FAC : SSC_TOK_LAST))
        else $error("setup flag query token wrong");
    out_restore_a: assert property (boot_go && !i_nv_data[SSC_NV_FAC_BIT] && !i_nv_data[SSC_NV_OFF_BIT] |=>
        o_wave_out_en == $past(i_nv_data[SSC_NV_WAVE_BIT]))
        else $error("output state not restored");
    out_off_a: assert property (boot_go && (i_nv_data[SSC_NV_OFF_BIT] || i_nv_data[SSC_NV_FAC_BIT]) |=>
        !o_wave_out_en)
        else $error("output enabled after power-on");
    sleep_legal_a: assert property (sleep_ok({10'h000, s_q.sleep_min}) && s_q.sleep_min <= SSC_SLEEP_MAX_MIN)
        else $error("illegal sleep delay stored");
    sleep_zero_a: assert property ($rose(o_sleep) |->
        $past(s_q.sleep_min) != 6'h00 || $past(cmd_go && cmd_op == SSC_OP_SLEEP_NOW))
        else $error("auto sleep with zero delay");
    sleep_now_a: assert property (cmd_go && i_ce && !cmd_query && cmd_op == SSC_OP_SLEEP_NOW |=> o_sleep)
        else $error("immediate sleep not entered");
    beep_round_a: assert property (cmd_go && i_ce && !cmd_query && cmd_num && cmd_op == SSC_OP_KEYB |=>
        o_key_beep_en == rounds_nonzero($past(cmd_arg)))
        else $error("key beep rounding wrong");
    // the boot load changes settings without a store write, so only changes made in run count
    nv_track_a: assert property ($past(s_q.st == SSC_RUN) && $changed(o_err_beep_en) |->
        o_nv_wr && o_nv_data[SSC_NV_ERR_BIT] == o_err_beep_en)
        else $error("setting change not written to storage");
    // a sleep command in the same cycle as a key press wins, so it is left out here
    restart_a: assert property (i_ce && i_key_press && s_q.st == SSC_RUN &&
        !(cmd_go && cmd_op == SSC_OP_SLEEP_NOW) |=>
        s_q.cyc_cnt == 28'h0000000 && s_q.min_cnt == 6'h00 && !o_sleep)
        else $error("activity did not restart sleep timer");

    query_c: cover property (cmd_go && i_ce && cmd_query ##1 o_wb_ack);
    autosleep_c: cover property (!o_sleep ##1 o_sleep && !$past(cmd_go));
    fac_boot_c: cover property (o_remote_dflt);
    bad_arg_c: cover property (s_q.resp_err);

endmodule : ssc_setup_cmd

// *** rtl/ssc_pkg.sv ***
// package: constants, opcodes, tokens and state layout of the system setup command handler
package ssc_pkg;

    // ---------------------------------------------------------------
    // clock and timing
    // ---------------------------------------------------------------
    localparam int SSC_CLK_HZ = 250_000_000;
    localparam logic [27:0] SSC_CYC_PER_SEC = 28'(SSC_CLK_HZ);
    localparam logic [5:0] SSC_SEC_PER_MIN = 6'h3C;
    localparam logic [5:0] SSC_SLEEP_STEP_MIN = 6'h0A;
    localparam logic [5:0] SSC_SLEEP_MAX_MIN = 6'h3C;

    // ---------------------------------------------------------------
    // register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] SSC_ADR_CMD = 8'h00;
    localparam logic [7:0] SSC_ADR_RESP = 8'h04;
    localparam logic [7:0] SSC_ADR_STATUS = 8'h08;

    // ---------------------------------------------------------------
    // command word fields
    // ---------------------------------------------------------------
    localparam int SSC_CMD_OP_LSB = 0;
    localparam int SSC_CMD_QUERY_BIT = 4;
    localparam int SSC_CMD_NUM_BIT = 5;
    localparam int SSC_CMD_ARG_LSB = 16;
    localparam logic signed [15:0] SSC_HALF_POS = 16'sh0008;
    localparam logic signed [15:0] SSC_HALF_NEG = -16'sh0008;

    // opcodes
    localparam logic [3:0] SSC_OP_SETUP = 4'h1;
    localparam logic [3:0] SSC_OP_OUTF = 4'h2;
    localparam logic [3:0] SSC_OP_SLEEP = 4'h3;
    localparam logic [3:0] SSC_OP_SLEEP_NOW = 4'h4;
    localparam logic [3:0] SSC_OP_KEYB = 4'h5;
    localparam logic [3:0] SSC_OP_ERRB = 4'h6;
    localparam logic [3:0] SSC_OP_SYNC = 4'h7;
    localparam logic [3:0] SSC_OP_WAVE = 4'h8;

    // character tokens
    localparam logic [7:0] SSC_TOK_LAST = 8'h01;
    localparam logic [7:0] SSC_TOK_FAC = 8'h02;
    localparam logic [7:0] SSC_TOK_OFF = 8'h03;
    localparam logic [7:0] SSC_TOK_ON = 8'h04;

    // response and status / non-volatile image field positions
    localparam int SSC_RESP_VALID_BIT = 8;
    localparam int SSC_RESP_ERR_BIT = 9;
    localparam int SSC_NV_FAC_BIT = 0;
    localparam int SSC_NV_OFF_BIT = 1;
    localparam int SSC_NV_SLEEP_LSB = 2;
    localparam int SSC_NV_KEY_BIT = 8;
    localparam int SSC_NV_ERR_BIT = 9;
    localparam int SSC_NV_SYNC_BIT = 10;
    localparam int SSC_NV_WAVE_BIT = 11;
    localparam int SSC_ST_SLEEP_BIT = 12;
    localparam int SSC_ST_RUN_BIT = 13;

    // factory defaults
    localparam logic [5:0] SSC_DEF_SLEEP = 6'h00;
    localparam logic SSC_DEF_KEYB = 1'b1;
    localparam logic SSC_DEF_ERRB = 1'b1;
    localparam logic SSC_DEF_SYNC = 1'b0;

    typedef enum logic {SSC_BOOT, SSC_RUN} ssc_state_t;

    typedef struct packed {
        ssc_state_t st;
        logic ack;
        logic [31:0] rdat;
        logic setup_fac;
        logic out_off;
        logic [5:0] sleep_min;
        logic key_beep;
        logic err_beep;
        logic sync_en;
        logic wave_on;
        logic asleep;
        logic remote_dflt;
        logic nv_wr;
        logic [15:0] nv_data;
        logic [7:0] resp_val;
        logic resp_valid;
        logic resp_err;
        logic [27:0] cyc_cnt;
        logic [5:0] sec_cnt;
        logic [5:0] min_cnt;
    } ssc_regs_t;

endpackage : ssc_pkg

// *** tb/ssc_nv_model.sv ***
// non-volatile store model: keeps the settings image of the handler across resets
`timescale 1ns/1ns

module ssc_nv_model #(
    parameter logic [15:0] P_INIT = 16'h0800
) (
    // clock
    input wire logic i_mclk,
    // store port
    input wire logic i_nv_wr,
    input wire logic [15:0] i_nv_data,
    output logic [15:0] o_nv_data
);
    // no reset on purpose: the image must outlive a power cycle of the handler
    logic [15:0] img_q = P_INIT;
    always @(posedge i_mclk) begin
        if (i_nv_wr === 1'b1) begin
            img_q <= i_nv_data;
        end
    end
    assign o_nv_data = img_q;
endmodule : ssc_nv_model

// *** tb/tb.sv ***
// testbench: power-on flags, sleep timer, beep and sync enables through wishbone
`timescale 1ns/1ns

module tb;
    import ssc_pkg::*;
    localparam int EXP_CYC = 10 * 60 * 4;
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, key = 1'b0, ce = 1'b1;
    logic [3:0] sel = 4'hF;
    logic [2:0] ens;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, wb_rd;
    logic ack, nv_wr, slp, wav, kb, eb, se, rdf, e;
    logic [15:0] nv_img, nv_out;
    logic [3:0] op;
    int failures = 0, cmp_count = 0, rdf_cnt = 0, seed = 48, x, base;
    int corner[4] = '{8, -7, -8, 7};

    always #2 i_mclk = ~i_mclk;
    // counts power-on pulses that reset the remote settings
    always @(posedge i_mclk) begin
        if (rdf === 1'b1) begin
            rdf_cnt <= rdf_cnt + 1;
        end
    end

    ssc_setup_cmd #(.P_CYC_PER_SEC(28'h0000004)) DUT (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(ce),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_key_press(key), .i_nv_data(nv_img), .o_nv_wr(nv_wr),
        .o_nv_data(nv_out), .o_sleep(slp), .o_wave_out_en(wav), .o_key_beep_en(kb), .o_err_beep_en(eb),
        .o_sync_out_en(se), .o_remote_dflt(rdf));
    ssc_nv_model NV (.i_mclk(i_mclk), .i_nv_wr(nv_wr), .i_nv_data(nv_out), .o_nv_data(nv_img));
    // the three enables side by side, indexed by opcode minus five
    assign ens = {se, eb, kb};

    function automatic logic [31:0] resp_of(input logic [7:0] v);
        return {23'h000000, 1'b1, v};
    endfunction : resp_of
    // rounding to nearest, half away from zero, with four fraction bits
    function automatic logic num_on(input int v);
        return (v >= 8 || v <= -8);
    endfunction : num_on

    task automatic stop_test();
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string name, input logic [31:0] ex, input logic [31:0] got);
        cmp_count++;
        if (got !== ex) begin
            $display("ERROR %s expected %h seen %h", name, ex, got);
            failures++;
        end
    endtask : chk

    // one classic cycle; a hung slave ends the run
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge i_mclk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            failures++;
            stop_test();
        end else begin
            wb_rd = rdat;
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
        end
    endtask : wb

    task automatic cmd(input logic [3:0] o, input logic q, input logic n, input logic [15:0] arg);
        wb(1'b1, SSC_ADR_CMD, {arg, 10'h000, n, q, o});
    endtask : cmd

    task automatic query(input logic [3:0] o, input logic [7:0] v, input string nm);
        cmd(o, 1'b1, 1'b0, 16'h0000);
        wb(1'b0, SSC_ADR_RESP, 32'h00000000);
        chk(nm, resp_of(v), wb_rd);
    endtask : query

    task automatic do_reset();
        i_resetn <= 1'b0;
        repeat (6) @(posedge i_mclk);
        i_resetn <= 1'b1;
        repeat (3) @(posedge i_mclk);
    endtask : do_reset

    initial begin
        do_reset();
        chk("wave", 1, wav);
        chk("key beep", 0, kb);
        query(SSC_OP_SETUP, SSC_TOK_LAST, "setup flag");
        query(SSC_OP_OUTF, SSC_TOK_LAST, "output flag");
        cmd(SSC_OP_OUTF, 1'b0, 1'b0, 16'(SSC_TOK_OFF));
        query(SSC_OP_OUTF, SSC_TOK_OFF, "output flag");
        do_reset();
        chk("wave off", 0, wav);
        cmd(SSC_OP_OUTF, 1'b0, 1'b0, 16'(SSC_TOK_LAST));
        cmd(SSC_OP_WAVE, 1'b0, 1'b0, 16'(SSC_TOK_ON));
        cmd(SSC_OP_SETUP, 1'b0, 1'b0, 16'(SSC_TOK_FAC));
        query(SSC_OP_SETUP, SSC_TOK_FAC, "setup flag");
        chk("nv image", 32'h0801, nv_img);
        base = rdf_cnt;
        do_reset();
        chk("wave prio", 0, wav);
        query(SSC_OP_WAVE, 8'h00, "wave query");
        chk("key default", SSC_DEF_KEYB, kb);
        chk("remote default", 1, rdf_cnt - base);
        // a token outside the two options is refused and leaves the flag alone
        cmd(SSC_OP_SETUP, 1'b0, 1'b0, 16'h0005);
        wb(1'b0, SSC_ADR_RESP, 32'h00000000);
        chk("setup error", 32'h00000200, wb_rd);
        query(SSC_OP_SETUP, SSC_TOK_FAC, "setup kept");
        // tokens first, then boundary and random numbers on all three enables
        for (int i = 0; i < 30; i++) begin
            op = 4'(5 + i % 3);
            x = (i < 10) ? corner[i % 4] : $random(seed) % 17;
            if (i < 6) begin
                e = i[0];
                cmd(op, 1'b0, 1'b0, 16'(e ? SSC_TOK_ON : SSC_TOK_OFF));
            end else begin
                e = num_on(x);
                cmd(op, 1'b0, 1'b1, 16'(x));
            end
            chk("enable", e, ens[i % 3]);
            query(op, {7'h00, e}, "enable query");
        end
        for (int m = 0; m <= 60; m += 10) begin
            cmd(SSC_OP_SLEEP, 1'b0, 1'b0, 16'(m));
            query(SSC_OP_SLEEP, 8'(m), "sleep minutes");
        end
        cmd(SSC_OP_SLEEP, 1'b0, 1'b0, 16'h0005);
        wb(1'b0, SSC_ADR_RESP, 32'h00000000);
        chk("sleep error", 1, wb_rd[SSC_RESP_ERR_BIT]);
        query(SSC_OP_SLEEP, 8'h3C, "sleep kept");
        // a command word written on only some lanes must not execute
        sel <= 4'h3;
        cmd(SSC_OP_SLEEP, 1'b0, 1'b0, 16'h0014);
        sel <= 4'hF;
        query(SSC_OP_SLEEP, 8'h3C, "sleep partial");
        cmd(SSC_OP_SLEEP, 1'b0, 1'b0, 16'h000A);
        // the last quiet cycle and the expiry edge, seen one edge late through the registers
        repeat (EXP_CYC - 1) @(posedge i_mclk);
        chk("awake early", 0, slp);
        @(posedge i_mclk);
        chk("asleep", 1, slp);
        key <= 1'b1;
        @(posedge i_mclk);
        key <= 1'b0;
        repeat (2) @(posedge i_mclk);
        chk("wake", 0, slp);
        cmd(SSC_OP_SLEEP, 1'b0, 1'b0, 16'h0000);
        repeat (EXP_CYC + 200) @(posedge i_mclk);
        chk("no auto sleep", 0, slp);
        cmd(SSC_OP_SLEEP_NOW, 1'b0, 1'b0, 16'h0000);
        chk("sleep now", 1, slp);
        // with the enable low a key press must not wake the frozen block
        ce <= 1'b0;
        key <= 1'b1;
        repeat (2) @(posedge i_mclk);
        key <= 1'b0;
        ce <= 1'b1;
        @(posedge i_mclk);
        chk("frozen", 1, slp);
        wb(1'b0, SSC_ADR_STATUS, 32'h00000000);
        chk("status", 2'b11, {wb_rd[SSC_ST_RUN_BIT], wb_rd[SSC_ST_SLEEP_BIT]});
        stop_test();
    end
endmodule : tb
